// file: ud_diag_regs.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - Diagnostic and trim registers are reachable only while the diagnostic gate is set.
// - Transceiver test enable gates all other diagnostic test bits.
// - With test enabled, bits 7 and 6 read D+ and D- receive levels.
// - With test enabled, bit 5 reads the differential comparator output.
// - Line force enable plus test enable arm the two force bits.
// - Armed force bits drive D- or D+ high, whatever the speed mode.
// - Receiver threshold trim, reset 4, acts only with diagnostic gate set.
// - Edge rate trim, reset 0x10, acts only with diagnostic gate set.
// - No-CRC bit drops transmit CRC16; receive checking stays unchanged.
// - Short frame bit lets the frame timer track short frames.
// - Function address register holds the 7-bit node address.
// - With address enable set, token addresses are compared to the stored address.
// - With address enable clear, all tokens are ignored except default-address ones.
// - Default-address respond lets endpoint 0 answer tokens to address zero.
// - Clearing node enable stops the node clock and resets these registers.
module ud_diag_regs
    import ud_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire ud_axi_req_t axi_req_in,
    output ud_axi_rsp_t axi_rsp_out,
    input wire logic node_enable_in,
    input wire logic low_speed_select_in,
    input wire logic dplus_rx_in,
    input wire logic dminus_rx_in,
    input wire logic diff_rx_in,
    input wire logic tok_valid_in,
    input wire logic [6:0] tok_addr_in,
    input wire logic default_address_respond_in,
    output logic node_clk_run_out,
    output logic line_force_oe_out,
    output logic force_dplus_out,
    output logic force_dminus_out,
    output logic [2:0] rx_threshold_trim_out,
    output logic [4:0] edge_rate_trim_out,
    output logic suppress_tx_crc_out,
    output logic short_frame_track_out,
    output logic tok_hit_out,
    output logic tok_default_hit_out
);

    // Register index of a byte address
    function automatic logic [UD_IDX_W-1:0] idx_of(input logic [31:0] a);
        idx_of = a[UD_IDX_W+1:2];
    endfunction

    // Register selected by index: 0 none, 1..4 map order
    function automatic logic [2:0] sel_of(input logic [31:0] a);
        logic [UD_IDX_W-1:0] i;
        i = idx_of(a);
        if (i == UD_XCVDIAG_IDX[UD_IDX_W-1:0]) begin
            sel_of = 3'h1;
        end else if (i == UD_TRIM_IDX[UD_IDX_W-1:0]) begin
            sel_of = 3'h2;
        end else if (i == UD_UTIL_IDX[UD_IDX_W-1:0]) begin
            sel_of = 3'h3;
        end else if (i == UD_FADDR_IDX[UD_IDX_W-1:0]) begin
            sel_of = 3'h4;
        end else begin
            sel_of = 3'h0;
        end
    endfunction

    // Register state
    logic [3:0] xcv_ctl_q;
    logic [2:0] vth_q;
    logic [4:0] edge_q;
    logic [7:0] util_q;
    logic [7:0] faddr_q;
    logic reg_rst;

    // Bus slave state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [31:0] waddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic do_write;
    logic [2:0] wsel;
    logic [2:0] rsel;
    logic [7:0] rbyte;

    // Pin synchronisers
    logic [2:0] rx_meta_q;
    logic [2:0] rx_sync_q;

    // Output flops
    logic node_clk_run_q;
    logic line_force_oe_q;
    logic force_dplus_q;
    logic force_dminus_q;
    logic [2:0] vth_out_q;
    logic [4:0] edge_out_q;
    logic nocrc_q;
    logic shortf_q;

    // Gates
    logic diag_gate;
    logic test_en;
    logic force_armed;

    assign diag_gate = util_q[UD_UT_DIAG];
    assign test_en = xcv_ctl_q[UD_XD_TEST];
    assign force_armed = test_en && xcv_ctl_q[UD_XD_FORCE_EN];

    // Registers fall back to reset while the node is disabled
    assign reg_rst = rst_in || !node_enable_in;

    // Two-flop synchronisers for the receive levels
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rx_meta_q <= 3'h0;
            rx_sync_q <= 3'h0;
        end else begin
            rx_meta_q <= {dplus_rx_in, dminus_rx_in, diff_rx_in};
            rx_sync_q <= rx_meta_q;
        end
    end

    // Write address channel
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            awready_q <= 1'b1;
            waddr_q <= 32'h0000_0000;
        end else if (awready_q && axi_req_in.awvalid) begin
            awready_q <= 1'b0;
            waddr_q <= axi_req_in.awaddr;
        end else if (bvalid_q && axi_req_in.bready) begin
            awready_q <= 1'b1;
        end
    end

    // Write data channel, low byte lane only
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wready_q <= 1'b1;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
        end else if (wready_q && axi_req_in.wvalid) begin
            wready_q <= 1'b0;
            wbyte_q <= axi_req_in.wdata[7:0];
            wlane_q <= axi_req_in.wstrb[0];
        end else if (bvalid_q && axi_req_in.bready) begin
            wready_q <= 1'b1;
        end
    end

    // Write performed once both halves are held
    assign do_write = !awready_q && !wready_q && !bvalid_q;
    assign wsel = sel_of(waddr_q);

    // Write response
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            bvalid_q <= 1'b0;
            bresp_q <= UD_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wsel == 3'h0) ? UD_RESP_DECERR : UD_RESP_OKAY;
        end else if (bvalid_q && axi_req_in.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Transceiver test control bits, writable only through the gate
    always_ff @(posedge mclk_in) begin
        if (reg_rst) begin
            xcv_ctl_q <= UD_REG_RST[3:0];
        end else if (do_write && wlane_q && wsel == 3'h1 && diag_gate) begin
            xcv_ctl_q <= wbyte_q[3:0];
        end
    end

    // Trim register, writable only through the gate
    always_ff @(posedge mclk_in) begin
        if (reg_rst) begin
            vth_q <= UD_TR_VTH_RST;
            edge_q <= UD_TR_EDGE_RST;
        end else if (do_write && wlane_q && wsel == 3'h2 && diag_gate) begin
            vth_q <= wbyte_q[UD_TR_VTH_LSB +: UD_TR_VTH_W];
            edge_q <= wbyte_q[UD_TR_EDGE_LSB +: UD_TR_EDGE_W];
        end
    end

    // Utility test register, reserved bits stored as written
    always_ff @(posedge mclk_in) begin
        if (reg_rst) begin
            util_q <= UD_REG_RST;
        end else if (do_write && wlane_q && wsel == 3'h3) begin
            util_q <= wbyte_q;
        end
    end

    // Function address register
    always_ff @(posedge mclk_in) begin
        if (reg_rst) begin
            faddr_q <= UD_REG_RST;
        end else if (do_write && wlane_q && wsel == 3'h4) begin
            faddr_q <= wbyte_q;
        end
    end

    // Read data selection
    assign rsel = sel_of(axi_req_in.araddr);
    always_comb begin
        rbyte = 8'h00;
        if (rsel == 3'h1) begin
            if (diag_gate) begin
                rbyte[3:0] = xcv_ctl_q;
                if (test_en) begin
                    rbyte[UD_XD_DPLUS] = rx_sync_q[2];
                    rbyte[UD_XD_DMINUS] = rx_sync_q[1];
                    rbyte[UD_XD_DIFF] = rx_sync_q[0];
                end
            end
        end else if (rsel == 3'h2) begin
            if (diag_gate) begin
                rbyte = {vth_q, edge_q};
            end
        end else if (rsel == 3'h3) begin
            rbyte = util_q;
        end else if (rsel == 3'h4) begin
            rbyte = faddr_q;
        end
    end

    // Read channel, answer one cycle after the address is taken
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= UD_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (arready_q && axi_req_in.arvalid) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= (rsel == 3'h0) ? UD_RESP_DECERR : UD_RESP_OKAY;
            rdata_q <= {24'h00_0000, rbyte};
        end else if (rvalid_q && axi_req_in.rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // Line forcing, independent of the speed mode
    always_ff @(posedge mclk_in) begin
        if (reg_rst) begin
            line_force_oe_q <= 1'b0;
            force_dplus_q <= 1'b0;
            force_dminus_q <= 1'b0;
        end else begin
            line_force_oe_q <= force_armed;
            force_dplus_q <= force_armed && xcv_ctl_q[UD_XD_FORCE_DP];
            force_dminus_q <= force_armed && xcv_ctl_q[UD_XD_FORCE_DM];
        end
    end

    // Trims reach the transceiver only with the gate set
    always_ff @(posedge mclk_in) begin
        if (reg_rst) begin
            vth_out_q <= UD_TR_VTH_RST;
            edge_out_q <= UD_TR_EDGE_RST;
        end else begin
            vth_out_q <= diag_gate ? vth_q : UD_TR_VTH_RST;
            edge_out_q <= diag_gate ? edge_q : UD_TR_EDGE_RST;
        end
    end

    // Test modes for transmit CRC and frame timer
    always_ff @(posedge mclk_in) begin
        if (reg_rst) begin
            nocrc_q <= 1'b0;
            shortf_q <= 1'b0;
        end else begin
            nocrc_q <= util_q[UD_UT_NOCRC];
            shortf_q <= util_q[UD_UT_SHORTF];
        end
    end

    // Node clock run request follows the enable
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            node_clk_run_q <= 1'b0;
        end else begin
            node_clk_run_q <= node_enable_in;
        end
    end

    // Token address matching
    ud_token_match u_match (
        .mclk_in(mclk_in),
        .rst_in(reg_rst),
        .tok_valid_in(tok_valid_in),
        .tok_addr_in(tok_addr_in),
        .addr_enable_in(faddr_q[UD_FA_EN]),
        .func_addr_in(faddr_q[UD_FA_ADDR_W-1:0]),
        .default_address_respond_in(default_address_respond_in),
        .tok_hit_out(tok_hit_out),
        .tok_default_hit_out(tok_default_hit_out)
    );

    // Bus answer from flops
    assign axi_rsp_out.awready = awready_q;
    assign axi_rsp_out.wready = wready_q;
    assign axi_rsp_out.bresp = bresp_q;
    assign axi_rsp_out.bvalid = bvalid_q;
    assign axi_rsp_out.arready = arready_q;
    assign axi_rsp_out.rdata = rdata_q;
    assign axi_rsp_out.rresp = rresp_q;
    assign axi_rsp_out.rvalid = rvalid_q;

    assign node_clk_run_out = node_clk_run_q;
    assign line_force_oe_out = line_force_oe_q;
    assign force_dplus_out = force_dplus_q;
    assign force_dminus_out = force_dminus_q;
    assign rx_threshold_trim_out = vth_out_q;
    assign edge_rate_trim_out = edge_out_q;
    assign suppress_tx_crc_out = nocrc_q;
    assign short_frame_track_out = shortf_q;

endmodule

// file: ud_pkg.sv
package ud_pkg;

    // Printed register offsets, kept as register indices
    localparam logic [31:0] UD_XCVDIAG_IDX = 32'h5000_1802;
    localparam logic [31:0] UD_TRIM_IDX = 32'h5000_1804;
    localparam logic [31:0] UD_UTIL_IDX = 32'h5000_1806;
    localparam logic [31:0] UD_FADDR_IDX = 32'h5000_1808;
    // Index bits decoded from a byte address (addr[13:2])
    localparam int UD_IDX_W = 12;

    // Transceiver diagnostic fields
    localparam int UD_XD_DPLUS = 7;
    localparam int UD_XD_DMINUS = 6;
    localparam int UD_XD_DIFF = 5;
    localparam int UD_XD_FORCE_EN = 3;
    localparam int UD_XD_FORCE_DM = 2;
    localparam int UD_XD_FORCE_DP = 1;
    localparam int UD_XD_TEST = 0;

    // Trim fields and reset values
    localparam int UD_TR_VTH_LSB = 5;
    localparam int UD_TR_VTH_W = 3;
    localparam int UD_TR_EDGE_LSB = 0;
    localparam int UD_TR_EDGE_W = 5;
    localparam logic [2:0] UD_TR_VTH_RST = 3'h4;
    localparam logic [4:0] UD_TR_EDGE_RST = 5'h10;

    // Utility test fields
    localparam int UD_UT_DIAG = 7;
    localparam int UD_UT_NOCRC = 6;
    localparam int UD_UT_SHORTF = 5;
    localparam int UD_UT_RES_W = 5;

    // Function address fields
    localparam int UD_FA_EN = 7;
    localparam int UD_FA_ADDR_W = 7;
    localparam logic [6:0] UD_DEFAULT_ADDR = 7'h00;

    // Common reset value of the other registers
    localparam logic [7:0] UD_REG_RST = 8'h00;

    // AXI4-Lite answers
    localparam logic [1:0] UD_RESP_OKAY = 2'h0;
    localparam logic [1:0] UD_RESP_DECERR = 2'h3;

    typedef struct packed {
        logic [31:0] awaddr;
        logic [2:0] awprot;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic [2:0] arprot;
        logic arvalid;
        logic rready;
    } ud_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } ud_axi_rsp_t;

endpackage

// file: ud_token_match.sv
`timescale 1ns/1ps

// Token address match against the stored function address
module ud_token_match
    import ud_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic tok_valid_in,
    input wire logic [6:0] tok_addr_in,
    input wire logic addr_enable_in,
    input wire logic [6:0] func_addr_in,
    input wire logic default_address_respond_in,
    output logic tok_hit_out,
    output logic tok_default_hit_out
);

    logic tok_hit_q;
    logic tok_default_hit_q;

    // Own address match, only with address enable set
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tok_hit_q <= 1'b0;
        end else begin
            tok_hit_q <= tok_valid_in && addr_enable_in && (tok_addr_in == func_addr_in);
        end
    end

    // Endpoint 0 default-address match, whatever the stored address
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tok_default_hit_q <= 1'b0;
        end else begin
            tok_default_hit_q <= tok_valid_in && default_address_respond_in
                && (tok_addr_in == UD_DEFAULT_ADDR);
        end
    end

    assign tok_hit_out = tok_hit_q;
    assign tok_default_hit_out = tok_default_hit_q;

endmodule

// file: ud_diag_regs_assertions.sv
`timescale 1ns/1ps

// Port checks of the diagnostic and address registers
module ud_diag_regs_assertions
    import ud_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire ud_axi_req_t axi_req_in,
    input wire ud_axi_rsp_t axi_rsp_out,
    input wire logic node_enable_in,
    input wire logic tok_valid_in,
    input wire logic [6:0] tok_addr_in,
    input wire logic default_address_respond_in,
    input wire logic node_clk_run_out,
    input wire logic line_force_oe_out,
    input wire logic force_dplus_out,
    input wire logic force_dminus_out,
    input wire logic [2:0] rx_threshold_trim_out,
    input wire logic [4:0] edge_rate_trim_out,
    input wire logic suppress_tx_crc_out,
    input wire logic short_frame_track_out,
    input wire logic tok_hit_out,
    input wire logic tok_default_hit_out
);
    default clocking dc @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    // Bus handshake steps
    sequence s_wr_taken;
        axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid && axi_rsp_out.wready;
    endsequence
    sequence s_rd_taken;
        axi_req_in.arvalid && axi_rsp_out.arready;
    endsequence
    sequence s_b_done;
        axi_rsp_out.bvalid && axi_req_in.bready;
    endsequence

    // Write answer rises the cycle after both halves are held, read answer the cycle after the address is taken
    a_wr_answer_next: assert property (s_wr_taken |=> ##1 axi_rsp_out.bvalid)
        else $error("write answer late");
    a_rd_answer_next: assert property (s_rd_taken |=> axi_rsp_out.rvalid && axi_rsp_out.rdata[31:8] == 24'h0)
        else $error("read answer late or wide");
    a_b_release_ready: assert property (s_b_done |=> !axi_rsp_out.bvalid && axi_rsp_out.awready)
        else $error("write channel not reopened");
    // Node enable low resets the trims, test modes, line forcing and own-address hit
    a_node_off_reset: assert property (!node_enable_in |=>
        rx_threshold_trim_out == UD_TR_VTH_RST && edge_rate_trim_out == UD_TR_EDGE_RST
        && !suppress_tx_crc_out && !short_frame_track_out && !line_force_oe_out && !tok_hit_out)
        else $error("node disable did not reset");
    a_clk_run_follow: assert property (1'b1 |=> node_clk_run_out == $past(node_enable_in))
        else $error("clock run request wrong");
    // Token matching
    a_hit_source: assert property (tok_hit_out || tok_default_hit_out |->
        $past(tok_valid_in) && $past(node_enable_in))
        else $error("hit without token");
    a_default_hit: assert property (tok_valid_in && node_enable_in |=>
        tok_default_hit_out == ($past(default_address_respond_in) && $past(tok_addr_in) == UD_DEFAULT_ADDR))
        else $error("default hit wrong");
    // Line forcing needs the force enable
    a_force_dp_armed: assert property (force_dplus_out |-> line_force_oe_out)
        else $error("dplus forced unarmed");
    a_force_dm_armed: assert property (force_dminus_out |-> line_force_oe_out)
        else $error("dminus forced unarmed");
endmodule

bind ud_diag_regs ud_diag_regs_assertions i_ud_diag_regs_assertions (.mclk_in(mclk_in), .rst_in(rst_in),
    .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out), .node_enable_in(node_enable_in),
    .tok_valid_in(tok_valid_in), .tok_addr_in(tok_addr_in), .node_clk_run_out(node_clk_run_out),
    .default_address_respond_in(default_address_respond_in), .line_force_oe_out(line_force_oe_out),
    .force_dplus_out(force_dplus_out), .force_dminus_out(force_dminus_out),
    .rx_threshold_trim_out(rx_threshold_trim_out), .edge_rate_trim_out(edge_rate_trim_out),
    .suppress_tx_crc_out(suppress_tx_crc_out), .short_frame_track_out(short_frame_track_out),
    .tok_hit_out(tok_hit_out), .tok_default_hit_out(tok_default_hit_out));

// file: ud_host_model.sv
`timescale 1ns/1ps

// Upstream host seen through the receive path
module ud_host_model (
    input wire logic mclk_in,
    input wire logic line_force_oe_in,
    input wire logic force_dplus_in,
    input wire logic force_dminus_in,
    output logic dplus_rx_out,
    output logic dminus_rx_out,
    output logic diff_rx_out,
    output logic tok_valid_out,
    output logic [6:0] tok_addr_out
);
    // Idle J unless the node forces the lines
    assign dplus_rx_out = line_force_oe_in ? force_dplus_in : 1'b1;
    assign dminus_rx_out = line_force_oe_in ? force_dminus_in : 1'b0;
    assign diff_rx_out = dplus_rx_out & ~dminus_rx_out;

    initial begin
        tok_valid_out = 1'b0;
        tok_addr_out = 7'h55;
    end

    // One token after a gap; address scrambled once released
    task automatic send_token(input logic [6:0] a, input int gap);
        repeat (gap) @(posedge mclk_in);
        tok_valid_out <= 1'b1;
        tok_addr_out <= a;
        @(posedge mclk_in);
        tok_valid_out <= 1'b0;
        tok_addr_out <= ~a;
        #1;
    endtask
endmodule

// file: ud_diag_regs_tb.sv
`timescale 1ns/1ps

// Self-checking bench for the diagnostic and address registers
module ud_diag_regs_tb
    import ud_pkg::*;
;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
    } ud_row_t;
    logic mclk_in, rst_in, node_en, lsm, dflt, dp, dm, df, tv, oe, fdp, fdm, run, sup, sft, hit, dhit;
    logic [6:0] ta;
    logic [2:0] vth;
    logic [4:0] edg;
    ud_axi_req_t req;
    ud_axi_rsp_t rsp;
    int num_errors, compares;
    ud_row_t rows[8];

    ud_diag_regs i_ud_diag_regs (.mclk_in(mclk_in), .rst_in(rst_in), .axi_req_in(req), .axi_rsp_out(rsp),
        .node_enable_in(node_en), .low_speed_select_in(lsm), .dplus_rx_in(dp), .dminus_rx_in(dm),
        .diff_rx_in(df), .tok_valid_in(tv), .tok_addr_in(ta), .default_address_respond_in(dflt),
        .node_clk_run_out(run), .line_force_oe_out(oe), .force_dplus_out(fdp), .force_dminus_out(fdm),
        .rx_threshold_trim_out(vth), .edge_rate_trim_out(edg), .suppress_tx_crc_out(sup),
        .short_frame_track_out(sft), .tok_hit_out(hit), .tok_default_hit_out(dhit));
    ud_host_model i_ud_host_model (.mclk_in(mclk_in), .line_force_oe_in(oe), .force_dplus_in(fdp),
        .force_dminus_in(fdm), .dplus_rx_out(dp), .dminus_rx_out(dm), .diff_rx_out(df),
        .tok_valid_out(tv), .tok_addr_out(ta));

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic finish_test();
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        logic awp, wp;
        awp = 1'b1;
        wp = 1'b1;
        req.awaddr <= a;
        req.wdata <= d;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        while (awp || wp) begin
            @(posedge mclk_in);
            awp = awp && !rsp.awready;
            wp = wp && !rsp.wready;
            req.awvalid <= awp;
            req.wvalid <= wp;
        end
        do @(posedge mclk_in); while (rsp.bvalid !== 1'b1);
        chk("bresp", {30'h0, r}, {30'h0, rsp.bresp});
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do @(posedge mclk_in); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge mclk_in); while (rsp.rvalid !== 1'b1);
        chk("rdata", e, rsp.rdata);
        chk("rresp", {30'h0, r}, {30'h0, rsp.rresp});
    endtask

    task automatic tok(input logic [6:0] a, input int g, input logic [1:0] e);
        i_ud_host_model.send_token(a, g);
        chk("hits", {30'h0, e}, {30'h0, hit, dhit});
    endtask

    // Hang guard
    initial begin
        repeat (5000) @(posedge mclk_in);
        num_errors++;
        finish_test();
    end

    initial begin
        rows[0] = '{32'h6018, 32'h80, 32'h80, UD_RESP_OKAY};
        rows[1] = '{32'h6008, 32'h05, 32'ha5, UD_RESP_OKAY};
        rows[2] = '{32'h6008, 32'h0b, 32'hab, UD_RESP_OKAY};
        rows[3] = '{32'h6008, 32'h0d, 32'h4d, UD_RESP_OKAY};
        rows[4] = '{32'h6010, 32'ha5, 32'ha5, UD_RESP_OKAY};
        rows[5] = '{32'h6020, 32'hffffff2a, 32'h2a, UD_RESP_OKAY};
        rows[6] = '{32'h6000, 32'h12, 32'h0, UD_RESP_DECERR};
        rows[7] = '{32'h6018, 32'hc0, 32'hc0, UD_RESP_OKAY};
        num_errors = 0;
        compares = 0;
        rst_in = 1'b1;
        node_en = 1'b1;
        lsm = 1'b1;
        dflt = 1'b0;
        req = '0;
        req.wstrb = 4'hf;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].r);
            repeat (6) @(posedge mclk_in);
            rd(rows[i].a, rows[i].e, rows[i].r);
        end
        chk("outs", 32'h14b5, {19'h0, vth, edg, sup, sft, oe, fdp, fdm});
        // Speed mode leaves forcing alone; test enable clear disarms the force bits
        lsm <= 1'b0;
        repeat (2) @(posedge mclk_in);
        chk("outs_ls", 32'h14b5, {19'h0, vth, edg, sup, sft, oe, fdp, fdm});
        wr(32'h6008, 32'h0e, UD_RESP_OKAY);
        repeat (2) @(posedge mclk_in);
        chk("outs_off", 32'h14b0, {19'h0, vth, edg, sup, sft, oe, fdp, fdm});
        rd(32'h6008, 32'h0e, UD_RESP_OKAY);
        // Token matching with and without address enable
        wr(32'h6020, 32'h85, UD_RESP_OKAY);
        tok(7'h05, 1, 2'b10);
        tok(7'h04, 3, 2'b00);
        dflt <= 1'b1;
        tok(7'h00, 1, 2'b01);
        wr(32'h6020, 32'h05, UD_RESP_OKAY);
        tok(7'h05, 1, 2'b00);
        tok(7'h00, 2, 2'b01);
        dflt <= 1'b0;
        // Diagnostic gate closed hides trim access
        wr(32'h6018, 32'h40, UD_RESP_OKAY);
        wr(32'h6010, 32'h1f, UD_RESP_OKAY);
        rd(32'h6010, 32'h0, UD_RESP_OKAY);
        chk("trims", 32'h90, {24'h0, vth, edg});
        wr(32'h6018, 32'ha0, UD_RESP_OKAY);
        rd(32'h6010, 32'ha5, UD_RESP_OKAY);
        chk("shortf", 32'h1, {31'h0, sft});
        // Node disable, then a mid-run reset
        for (int k = 0; k < 2; k++) begin
            wr(32'h6020, 32'h85, UD_RESP_OKAY);
            node_en <= (k != 0);
            rst_in <= (k != 0);
            repeat (2) @(posedge mclk_in);
            chk("clk_run", 32'h0, {31'h0, run});
            chk("trims", 32'h90, {24'h0, vth, edg});
            node_en <= 1'b1;
            rst_in <= 1'b0;
            @(posedge mclk_in);
            rd(32'h6020, 32'h0, UD_RESP_OKAY);
        end
        finish_test();
    end
endmodule
